//--- hw/fhp_defines.svh
// Timing constants of the flash host pin controller
// How it works
// R01: Device holds 1,048,576 bytes on twenty address pins, sixteen 64K blocks.
// R02: Block erase clears exactly one block, typically 1.6 s.
// R03: Device can suspend an erase so other blocks can be read.
// R04: Each write or erase starts with two write cycles to the command interface.
// R05: Device's state machine runs the whole algorithm alone once the command is taken.
// R06: Each program writes one byte, typically within 8 us.
// R07: Device keeps a readable status register of activity and success.
// R08: Device holds ready_busy_n low while erasing or writing.
// R09: Device holds ready_busy_n high when idle, suspended or powered down.
// R10: Device always drives ready_busy_n, never floats it.
// R11: Low powerdown_reset_n keeps device powered down, state machine reset, status cleared.
// R12: Low powerdown_reset_n refuses every erase and byte write.
// R13: After powerdown_reset_n rises, wait 400 ns to read, 1 us to write.
// R14: Device floats data_pins when chip select or output gate is high.
// R15: Device drives data_pins only while output gate and chip select are low.
// R16: Address and data are captured on write strobe rising edge; host holds them.
// R17: data_pins take commands on writes, return array, status or identifier on reads.
// R18: Low program supply blocks all writes and erases.
// R19: Host programs zeros only into ones; sends ones for bits already zero.
`ifndef FHP_DEFINES_SVH
`define FHP_DEFINES_SVH

`define FHP_CLK_NS 100
`define FHP_T_RD_WAKE_NS 400
`define FHP_T_WR_WAKE_NS 1000
`define FHP_T_WE_LOW_NS 100
`define FHP_T_ACC_NS 85
`define FHP_T_SETTLE_NS 200
`define FHP_CYC_UP(ns) (((ns) + `FHP_CLK_NS - 1) / `FHP_CLK_NS)
`define FHP_RD_WAKE_CYC `FHP_CYC_UP(`FHP_T_RD_WAKE_NS)
`define FHP_WR_WAKE_CYC `FHP_CYC_UP(`FHP_T_WR_WAKE_NS)
`define FHP_WE_LOW_CYC `FHP_CYC_UP(`FHP_T_WE_LOW_NS)
`define FHP_SYNC_STAGES 2
`define FHP_RD_WAIT_CYC (`FHP_CYC_UP(`FHP_T_ACC_NS) + `FHP_SYNC_STAGES)
`define FHP_SETTLE_CYC `FHP_CYC_UP(`FHP_T_SETTLE_NS)
`define FHP_ADDR_W 20
`define FHP_DATA_W 8

`endif

//--- hw/fhp_host.sv
// Host-side controller driving the pins of a byte-wide block-erasable flash
`timescale 1ns/1ps
`include "fhp_defines.svh"
module fhp_host import fhp_pkg::*; (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic pd_req,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire fhp_op_t cmd_op,
  input wire logic [19:0] cmd_addr,
  input wire logic [7:0] cmd_code,
  input wire logic [7:0] cmd_data,
  input wire logic [7:0] cmd_old,
  input wire logic cmd_mask,
  input wire logic cmd_wait,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic dev_ready,
  output logic chip_select_n,
  output logic output_gate_n,
  output logic write_strobe_n,
  output logic [19:0] address_pins,
  output logic [7:0] data_pins_o,
  output logic data_pins_oe,
  input wire logic [7:0] data_pins_i,
  input wire logic ready_busy_n,
  output logic powerdown_reset_n
);
  localparam logic [3:0] RD_WAKE = 4'(`FHP_RD_WAKE_CYC);
  localparam logic [3:0] WR_WAKE = 4'(`FHP_WR_WAKE_CYC);
  localparam logic [3:0] WE_LOW = 4'(`FHP_WE_LOW_CYC);
  localparam logic [3:0] RD_WAIT = 4'(`FHP_RD_WAIT_CYC);
  localparam logic [3:0] SETTLE = 4'(`FHP_SETTLE_CYC);

  // Only clear bits that go 1 to 0; bits already zero are sent as one
  function automatic logic [7:0] prog_pattern(input logic [7:0] new_val, input logic [7:0] old_val);
    prog_pattern = new_val | ~old_val;
  endfunction

  fhp_state_t state_ff;
  logic [3:0] wake_ff;
  logic [3:0] cnt_ff;
  logic [19:0] addr_ff;
  logic [7:0] dout_ff;
  logic [7:0] byte2_ff;
  logic [7:0] old_ff;
  logic second_ff;
  logic mask_ff;
  logic wait_ff;
  logic pd_n_ff;
  logic cs_n_ff;
  logic oe_n_ff;
  logic we_n_ff;
  logic doe_ff;
  logic rsp_valid_ff;
  logic [7:0] rsp_data_ff;
  logic [8:0] pins_q;
  logic rb_q;
  logic [7:0] din_q;
  logic take;
  logic is_write;

  fhp_sync u_sync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .d_async({ready_busy_n, data_pins_i}),
    .q(pins_q)
  );
  assign rb_q = pins_q[8];
  assign din_q = pins_q[7:0];

  // Reads open earlier after wake than command writes do
  assign is_write = (cmd_op == FHP_OP_WRITE1) || (cmd_op == FHP_OP_WRITE2);
  always_comb begin
    cmd_ready = 1'b0;
    if (ce && state_ff == FHP_ST_IDLE && !pd_req && pd_n_ff && cmd_op != FHP_OP_SPARE) begin
      cmd_ready = is_write ? (wake_ff >= WR_WAKE) : (wake_ff >= RD_WAKE); // R13 R12
    end
  end
  assign take = cmd_valid && cmd_ready;

  // Powerdown line and the wake timer after its release
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pd_n_ff <= 1'b0;
      wake_ff <= 4'h0;
    end else if (ce) begin
      if (state_ff == FHP_ST_PD || (state_ff == FHP_ST_IDLE && pd_req)) begin
        pd_n_ff <= !pd_req && state_ff == FHP_ST_PD;
        wake_ff <= 4'h0;
      end else if (wake_ff < WR_WAKE) begin
        wake_ff <= wake_ff + 4'h1; // R13
      end
    end
  end

  // Sequencer for pin cycles
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_ff <= FHP_ST_PD;
      cnt_ff <= 4'h0;
      addr_ff <= 20'h00000;
      dout_ff <= 8'h00;
      byte2_ff <= 8'h00;
      old_ff <= 8'h00;
      second_ff <= 1'b0;
      mask_ff <= 1'b0;
      wait_ff <= 1'b0;
      cs_n_ff <= 1'b1;
      oe_n_ff <= 1'b1;
      we_n_ff <= 1'b1;
      doe_ff <= 1'b0;
    end else if (ce) begin
      unique case (state_ff)
        FHP_ST_PD: begin
          if (!pd_req) begin
            state_ff <= FHP_ST_IDLE;
          end
        end
        FHP_ST_IDLE: begin
          if (pd_req) begin
            state_ff <= FHP_ST_PD;
          end else if (take && is_write) begin
            addr_ff <= cmd_addr;
            dout_ff <= cmd_code;
            byte2_ff <= cmd_mask ? prog_pattern(cmd_data, cmd_old) : cmd_data; // R19
            old_ff <= cmd_old;
            mask_ff <= cmd_mask;
            second_ff <= (cmd_op == FHP_OP_WRITE2); // R04
            wait_ff <= cmd_wait;
            cs_n_ff <= 1'b0;
            doe_ff <= 1'b1;
            state_ff <= FHP_ST_WSETUP;
          end else if (take) begin
            addr_ff <= cmd_addr;
            cs_n_ff <= 1'b0;
            oe_n_ff <= 1'b0; // R15
            cnt_ff <= RD_WAIT - 4'h1;
            state_ff <= FHP_ST_RLOW;
          end
        end
        FHP_ST_WSETUP: begin
          we_n_ff <= 1'b0;
          cnt_ff <= WE_LOW - 4'h1;
          state_ff <= FHP_ST_WLOW;
        end
        FHP_ST_WLOW: begin
          if (cnt_ff == 4'h0) begin
            we_n_ff <= 1'b1;
            state_ff <= FHP_ST_WHOLD;
          end else begin
            cnt_ff <= cnt_ff - 4'h1;
          end
        end
        FHP_ST_WHOLD: begin
          // Address and data stay put for this whole cycle past the rising edge
          if (second_ff) begin
            dout_ff <= byte2_ff; // R04 R16
            second_ff <= 1'b0;
            state_ff <= FHP_ST_WSETUP;
          end else begin
            doe_ff <= 1'b0;
            cs_n_ff <= 1'b1;
            cnt_ff <= SETTLE - 4'h1;
            state_ff <= wait_ff ? FHP_ST_SETTLE : FHP_ST_IDLE;
          end
        end
        FHP_ST_SETTLE: begin
          // Busy takes a moment to fall after the command lands
          if (cnt_ff == 4'h0) begin
            state_ff <= FHP_ST_BUSY;
          end else begin
            cnt_ff <= cnt_ff - 4'h1;
          end
        end
        FHP_ST_BUSY: begin
          if (rb_q) begin
            state_ff <= FHP_ST_IDLE; // R08 R09
          end
        end
        FHP_ST_RLOW: begin
          if (cnt_ff == 4'h0) begin
            oe_n_ff <= 1'b1; // R14
            cs_n_ff <= 1'b1;
            state_ff <= FHP_ST_IDLE;
          end else begin
            cnt_ff <= cnt_ff - 4'h1;
          end
        end
      endcase
    end
  end

  // Answer to the user: read data, or completion of a write sequence
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rsp_valid_ff <= 1'b0;
      rsp_data_ff <= 8'h00;
    end else if (ce) begin
      rsp_valid_ff <= 1'b0;
      if (state_ff == FHP_ST_RLOW && cnt_ff == 4'h0) begin
        rsp_valid_ff <= 1'b1;
        rsp_data_ff <= din_q; // R17
      end else if (state_ff == FHP_ST_WHOLD && !second_ff && !wait_ff) begin
        rsp_valid_ff <= 1'b1;
        rsp_data_ff <= 8'h00;
      end else if (state_ff == FHP_ST_BUSY && rb_q) begin
        rsp_valid_ff <= 1'b1;
        rsp_data_ff <= 8'h00;
      end
    end
  end

  assign rsp_valid = rsp_valid_ff;
  assign rsp_data = rsp_data_ff;
  assign dev_ready = rb_q;
  assign chip_select_n = cs_n_ff;
  assign output_gate_n = oe_n_ff;
  assign write_strobe_n = we_n_ff;
  assign address_pins = addr_ff;
  assign data_pins_o = dout_ff;
  assign data_pins_oe = doe_ff;
  assign powerdown_reset_n = pd_n_ff;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst || !ce);

  sequence s_first_done;
    $rose(write_strobe_n) && second_ff;
  endsequence
  sequence s_busy_end;
    state_ff == FHP_ST_BUSY && rb_q;
  endsequence
  sequence s_read_open;
    $fell(output_gate_n) && !chip_select_n;
  endsequence

  a_no_bus_fight: assert property (data_pins_oe |-> output_gate_n) // R14
    else $error("data driven while output gate low");
  a_write_wake: assert property (!write_strobe_n |-> powerdown_reset_n && wake_ff >= 4'ha) // R12 R13
    else $error("write strobe before wake time");
  a_read_wake: assert property (!output_gate_n |-> powerdown_reset_n && wake_ff >= 4'h4) // R13
    else $error("read before wake time");
  a_wake_quiet: assert property ($rose(powerdown_reset_n) |-> (write_strobe_n && output_gate_n)[*4]) // R13
    else $error("pin cycle too soon after wake");
  a_strobe_hold: assert property ($rose(write_strobe_n) |->
      address_pins == $past(address_pins) && data_pins_o == $past(data_pins_o)
      && data_pins_oe && !chip_select_n ##1 address_pins == $past(address_pins)) // R16
    else $error("address or data moved around strobe edge");
  a_two_cycle: assert property (s_first_done |-> ##2 $fell(write_strobe_n)) // R04
    else $error("second command cycle missing");
  a_prog_pattern: assert property ($rose(write_strobe_n) && mask_ff && !second_ff
      && $past(state_ff, 4) != FHP_ST_IDLE |-> (~old_ff & ~data_pins_o) == 8'h00) // R19
    else $error("zero programmed over a zero bit");
  a_busy_wait: assert property (s_busy_end |=> rsp_valid && state_ff == FHP_ST_IDLE) // R08 R09
    else $error("busy release not answered");
  a_read_answer: assert property (s_read_open |-> !output_gate_n[*3] ##1 (rsp_valid && output_gate_n)) // R15
    else $error("read answer timing wrong");
endmodule

//--- hw/fhp_pkg.sv
// Types shared by the flash host pin controller
package fhp_pkg;

  typedef enum logic [1:0] {
    FHP_OP_READ = 2'b00,
    FHP_OP_WRITE1 = 2'b01,
    FHP_OP_WRITE2 = 2'b10,
    FHP_OP_SPARE = 2'b11
  } fhp_op_t;

  typedef enum logic [2:0] {
    FHP_ST_IDLE = 3'b000,
    FHP_ST_WSETUP = 3'b001,
    FHP_ST_WLOW = 3'b010,
    FHP_ST_WHOLD = 3'b011,
    FHP_ST_RLOW = 3'b100,
    FHP_ST_SETTLE = 3'b101,
    FHP_ST_BUSY = 3'b110,
    FHP_ST_PD = 3'b111
  } fhp_state_t;

endpackage

//--- hw/fhp_sync.sv
// Two-stage synchroniser for the flash pins read back by the host
`timescale 1ns/1ps
module fhp_sync (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [8:0] d_async,
  output logic [8:0] q
);
  logic [8:0] meta_ff;
  logic [8:0] q_ff;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      meta_ff <= 9'h000;
      q_ff <= 9'h000;
    end else if (ce) begin
      meta_ff <= d_async;
      q_ff <= meta_ff;
    end
  end

  assign q = q_ff;
endmodule

//--- test/fhp_dev_model.sv
// Behavioural flash device on the far side of the host pins
`timescale 1ns/1ps
module fhp_dev_model #(
  parameter logic [7:0] CMD_PROG = 8'h10,
  parameter logic [7:0] CMD_ERASE = 8'h20,
  parameter logic [7:0] CMD_STATUS = 8'h30,
  parameter logic [7:0] CMD_SUSPEND = 8'h40,
  parameter logic [7:0] CMD_RESUME = 8'h50,
  parameter int PROG_NS = 800,
  parameter int ERASE_NS = 5000
) (
  input wire logic chip_select_n,
  input wire logic output_gate_n,
  input wire logic write_strobe_n,
  input wire logic [19:0] address_pins,
  input wire logic [7:0] data_pins,
  input wire logic lockout,
  input wire logic powerdown_reset_n,
  output logic ready_busy_n,
  output logic dev_oe,
  output logic [7:0] dev_q,
  output int twice_count
);
  logic [7:0] mem [0:1048575];
  logic busy = 1'b0;
  logic fail = 1'b0;
  logic show_st = 1'b0;
  logic [7:0] pend = 8'h00;
  realtime wake_t = 0.0;
  int erase_left = 0;
  logic suspended = 1'b0;
  logic [3:0] erase_blk = 4'h0;
  initial begin
    twice_count = 0;
    foreach (mem[i]) mem[i] = 8'hff;
  end
  assign ready_busy_n = !busy || !powerdown_reset_n;
  assign dev_oe = !chip_select_n && !output_gate_n && powerdown_reset_n;
  assign dev_q = show_st ? {!busy, 2'b00, fail, 4'h0} : mem[address_pins];
  always @(negedge powerdown_reset_n) begin
    fail = 1'b0;
    show_st = 1'b0;
    pend = 8'h00;
    erase_left = 0;
    suspended = 1'b0;
    busy = 1'b0;
  end
  always @(posedge powerdown_reset_n) wake_t = $realtime;
  // A program blocks this process, so writes during it are ignored
  always @(posedge write_strobe_n) begin : take_write
    logic [19:0] a;
    logic [7:0] d;
    a = address_pins;
    d = data_pins;
    if (powerdown_reset_n === 1'b1 && !chip_select_n && $realtime - wake_t >= 1000.0) begin
      if (erase_left > 0) begin
        // While an erase is pending, suspend and resume are acted on, read mode (ff) shows the array and any other byte shows status
        if (d == CMD_SUSPEND && !suspended) begin
          suspended = 1'b1;
          busy = 1'b0;
        end else if (d == CMD_RESUME && suspended) begin
          suspended = 1'b0;
          busy = 1'b1;
        end
        show_st = (d != 8'hff);
      end else if (pend == 8'h00) begin
        pend = (d == CMD_PROG || d == CMD_ERASE) ? d : 8'h00;
        show_st = (d == CMD_STATUS);
      end else if (pend == CMD_ERASE) begin
        busy = 1'b1;
        show_st = 1'b1;
        erase_blk = a[19:16];
        erase_left = ERASE_NS;
        pend = 8'h00;
      end else begin
        busy = 1'b1;
        show_st = 1'b1;
        #PROG_NS;
        if (lockout) fail = 1'b1;
        else begin
          twice_count += $countones(~mem[a] & ~d);
          mem[a] = mem[a] & d;
        end
        busy = 1'b0;
        pend = 8'h00;
      end
    end
  end
  // Erase time runs down in steps and stands still while suspended
  always #100 begin
    if (erase_left > 0 && !suspended) begin
      erase_left -= 100;
      if (erase_left <= 0) begin
        if (lockout) fail = 1'b1;
        else for (int i = 0; i < 65536; i++) mem[{erase_blk, i[15:0]}] = 8'hff;
        busy = 1'b0;
      end
    end
  end
endmodule

//--- test/test_fhp_host.sv
// Self-checking bench of the flash host pin controller
`timescale 1ns/1ps
module test_fhp_host import fhp_pkg::*;;
  localparam logic [7:0] CMD_PROG = 8'h10;
  localparam logic [7:0] CMD_ERASE = 8'h20;
  localparam logic [7:0] CMD_STATUS = 8'h30;
  localparam logic [7:0] CMD_SUSPEND = 8'h40;
  localparam logic [7:0] CMD_RESUME = 8'h50;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic pd_req = 1'b0;
  logic cmd_valid = 1'b0;
  fhp_op_t cmd_op = FHP_OP_READ;
  logic [19:0] cmd_addr = 20'h00000;
  logic [7:0] cmd_code = 8'h00;
  logic [7:0] cmd_data = 8'h00;
  logic [7:0] cmd_old = 8'hff;
  logic cmd_mask = 1'b0;
  logic cmd_wait = 1'b0;
  logic lockout = 1'b0;
  logic saw_busy = 1'b0;
  logic hold_wait = 1'b1;
  logic cmd_ready, rsp_valid, dev_ready, chip_select_n, output_gate_n, write_strobe_n;
  logic data_pins_oe, ready_busy_n, powerdown_reset_n, dev_oe;
  logic [19:0] address_pins;
  logic [7:0] rsp_data, data_pins_o, data_pins_i, dev_q, got;
  int twice_count;
  int fail_count = 0;
  int compares = 0;
  always #50 core_clk = ~core_clk;
  // Undriven bus shows the inverse of the host's last byte, never a kind value
  assign data_pins_i = data_pins_oe ? data_pins_o : (dev_oe ? dev_q : ~data_pins_o);
  always @(posedge core_clk) if (ready_busy_n === 1'b0) saw_busy <= 1'b1;
  fhp_host u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .ce(1'b1), .pd_req(pd_req),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
    .cmd_code(cmd_code), .cmd_data(cmd_data), .cmd_old(cmd_old), .cmd_mask(cmd_mask),
    .cmd_wait(cmd_wait), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .dev_ready(dev_ready),
    .chip_select_n(chip_select_n), .output_gate_n(output_gate_n), .write_strobe_n(write_strobe_n),
    .address_pins(address_pins), .data_pins_o(data_pins_o), .data_pins_oe(data_pins_oe),
    .data_pins_i(data_pins_i), .ready_busy_n(ready_busy_n), .powerdown_reset_n(powerdown_reset_n));
  fhp_dev_model #(.CMD_PROG(CMD_PROG), .CMD_ERASE(CMD_ERASE), .CMD_STATUS(CMD_STATUS),
    .CMD_SUSPEND(CMD_SUSPEND), .CMD_RESUME(CMD_RESUME)) u_dev (
    .chip_select_n(chip_select_n), .output_gate_n(output_gate_n), .write_strobe_n(write_strobe_n),
    .address_pins(address_pins), .data_pins(data_pins_i), .lockout(lockout),
    .powerdown_reset_n(powerdown_reset_n), .ready_busy_n(ready_busy_n), .dev_oe(dev_oe),
    .dev_q(dev_q), .twice_count(twice_count));
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick;
    @(posedge core_clk);
    #1;
  endtask
  task automatic run(input fhp_op_t op, input logic [19:0] a, input logic [7:0] c, input logic [7:0] d);
    int n;
    n = 0;
    tick();
    cmd_op = op;
    cmd_addr = a;
    cmd_code = c;
    cmd_data = d;
    cmd_wait = (op == FHP_OP_WRITE2) && hold_wait;
    cmd_valid = 1'b1;
    while (cmd_ready !== 1'b1 && n < 400) begin
      tick();
      n++;
    end
    tick();
    cmd_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 2000) begin
      tick();
      n++;
    end
    if (n >= 2000) chk("answer", 8'h01, 8'h00);
    got = rsp_data;
  endtask
  task automatic prog(input logic [19:0] a, input logic [7:0] d);
    run(FHP_OP_WRITE2, a, CMD_PROG, d);
    chk("write answer", 8'h00, got);
  endtask
  task automatic rd(input string what, input logic [19:0] a, input logic [7:0] exp);
    run(FHP_OP_READ, a, 8'h00, 8'h00);
    chk(what, exp, got);
  endtask
  task automatic t_prog;
    prog(20'h12345, 8'h3c);
    rd("status", 20'h12345, 8'h80);
    chk("busy seen", 8'h01, {7'h00, saw_busy});
    chk("ready after", 8'h01, {7'h00, dev_ready});
    run(FHP_OP_WRITE1, 20'h12345, 8'hff, 8'h00);
    rd("byte", 20'h12345, 8'h3c);
    cmd_mask = 1'b1;
    cmd_old = 8'h3c;
    prog(20'h12345, 8'h34);
    cmd_mask = 1'b0;
    chk("twice", 8'h00, twice_count[7:0]);
  endtask
  task automatic t_erase;
    prog(20'h2ffff, 8'h00);
    prog(20'h30000, 8'h5a);
    run(FHP_OP_WRITE2, 20'h20000, CMD_ERASE, 8'hd0);
    run(FHP_OP_WRITE1, 20'h0, 8'hff, 8'h00);
    rd("erased", 20'h2ffff, 8'hff);
    rd("next block", 20'h30000, 8'h5a);
    rd("far block", 20'h12345, 8'h34);
  endtask
  task automatic t_suspend;
    int n;
    n = 0;
    cmd_op = FHP_OP_SPARE;
    tick();
    chk("spare refused", 8'h00, {7'h00, cmd_ready});
    prog(20'h2ffff, 8'h00);
    hold_wait = 1'b0;
    run(FHP_OP_WRITE2, 20'h20000, CMD_ERASE, 8'hd0);
    hold_wait = 1'b1;
    run(FHP_OP_WRITE1, 20'h0, CMD_SUSPEND, 8'h00);
    repeat (2) tick();
    chk("ready in suspend", 8'h01, {7'h00, dev_ready});
    run(FHP_OP_WRITE1, 20'h0, 8'hff, 8'h00);
    rd("other block in suspend", 20'h30000, 8'h5a);
    rd("block held", 20'h2ffff, 8'h00);
    run(FHP_OP_WRITE1, 20'h0, CMD_RESUME, 8'h00);
    repeat (2) tick();
    chk("busy after resume", 8'h00, {7'h00, dev_ready});
    while (dev_ready !== 1'b1 && n < 200) begin
      tick();
      n++;
    end
    run(FHP_OP_WRITE1, 20'h0, 8'hff, 8'h00);
    rd("erased after resume", 20'h2ffff, 8'hff);
  endtask
  task automatic t_lock;
    lockout = 1'b1;
    prog(20'h40000, 8'h00);
    rd("lock status", 20'h40000, 8'h90);
    lockout = 1'b0;
    run(FHP_OP_WRITE1, 20'h0, 8'hff, 8'h00);
    rd("locked byte", 20'h40000, 8'hff);
  endtask
  task automatic t_pd;
    int n;
    n = 0;
    tick();
    pd_req = 1'b1;
    cmd_op = FHP_OP_READ;
    repeat (4) tick();
    chk("pd pin", 8'h00, {7'h00, powerdown_reset_n});
    chk("ready in pd", 8'h00, {7'h00, cmd_ready});
    pd_req = 1'b0;
    while (powerdown_reset_n !== 1'b1 && n < 10) begin
      tick();
      n++;
    end
    n = 0;
    while (cmd_ready !== 1'b1 && n < 40) begin
      tick();
      n++;
    end
    chk("read wake", 8'h01, {7'h00, n >= 4});
    // Let ready settle for the new op before polling it again
    cmd_op = FHP_OP_WRITE1;
    tick();
    n++;
    while (cmd_ready !== 1'b1 && n < 40) begin
      tick();
      n++;
    end
    chk("write wake", 8'h01, {7'h00, n >= 10});
    run(FHP_OP_WRITE1, 20'h0, CMD_STATUS, 8'h00);
    rd("status after pd", 20'h0, 8'h80);
  endtask
  task automatic summarize;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #3000000;
    fail_count++;
    summarize();
  end
  initial begin
    repeat (8) tick();
    sys_rst = 1'b0;
    t_prog();
    t_erase();
    t_suspend();
    t_lock();
    t_pd();
    summarize();
  end
endmodule
